// ### src/mps_pkg.sv
// Package for the memory pin scan chain: constants, types and chain layout
package mps_pkg;

    // Chain length and special positions (1-based as listed)
    localparam int CHAIN_LEN = 67;
    localparam int POS_UNASSIGNED_A = 56;
    localparam int POS_UNASSIGNED_B = 57;
    localparam int POS_SPARE_MARKER = 20;

    // Output FIFO shape
    localparam int FIFO_WIDTH = 1;
    localparam int FIFO_DEPTH = 8;

    // Clock and timing
    localparam real CLK_PERIOD_NS = 5.0;
    localparam real SCAN_ENTRY_LEAD_NS = 3.0;
    localparam int SCAN_ENTRY_LEAD_CYC = (int'($ceil(SCAN_ENTRY_LEAD_NS / CLK_PERIOD_NS)) < 1) ? 1 :
        int'($ceil(SCAN_ENTRY_LEAD_NS / CLK_PERIOD_NS));

    // Synchroniser depth
    localparam int SYNC_STAGES = 2;

    // Chain vector type
    typedef logic [CHAIN_LEN-1:0] mps_chain_t;

    // Scan control pins, grouped
    typedef struct packed {
        logic scanEntrySelect;
        logic shiftCaptureSelect;
        logic scanStrobe;
        logic testOutGate;
    } mps_scan_pins_s;

    // Normal-function view of the shared pins
    typedef struct packed {
        logic initClearPin;
        logic pinSwapSelect;
        logic chipSelectN;
        logic writeStrobeLane0;
    } mps_shared_pins_s;

    // Scan sequencer state
    typedef enum logic [1:0] {
        MPS_IDLE,
        MPS_ARMED,
        MPS_SCAN
    } mps_state_e;

endpackage : mps_pkg

// ### src/mps_fifo.sv
// Parameterised valid/ready FIFO for the serial scan output stream
`timescale 1ns/1ps
module mps_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Flush
    input wire logic flush,
    // Fill side
    input wire logic inValid,
    input wire logic [WIDTH-1:0] inData,
    output logic inReady,
    // Drain side
    output logic outValid,
    output logic [WIDTH-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH]; // Storage
    logic [AW-1:0] wrPtr_r; // Write pointer
    logic [AW-1:0] rdPtr_r; // Read pointer
    logic [AW:0] count_r; // Occupancy
    logic doWr; // Write this cycle
    logic doRd; // Read this cycle

    // Full when the occupancy reaches the depth
    assign inReady = (count_r != (AW+1)'(DEPTH));
    assign outValid = (count_r != '0);
    assign outData = mem[rdPtr_r];
    assign doWr = inValid && inReady;
    assign doRd = outValid && outReady;

    // Storage write
    always_ff @(posedge clk) begin
        if (doWr) begin
            mem[wrPtr_r] <= inData;
        end
    end

    // Pointers and occupancy
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else if (flush) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (doWr) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH-1)) ? '0 : wrPtr_r + AW'(1);
            end
            if (doRd) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH-1)) ? '0 : rdPtr_r + AW'(1);
            end
            case ({doWr, doRd})
                2'b10: count_r <= count_r + (AW+1)'(1);
                2'b01: count_r <= count_r - (AW+1)'(1);
                default: count_r <= count_r;
            endcase
        end
    end
endmodule : mps_fifo

// ### src/mps_scan_chain.sv
// Pin scan chain of the memory device: capture, shift and gated serial output
`timescale 1ns/1ps
module mps_scan_chain
    import mps_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Dedicated scan entry pin
    input wire logic scanEntrySelect,
    // Shared pins as seen on the balls
    input wire mps_shared_pins_s sharedPins,
    // Pad levels in chain order, bit 0 is position 1
    input wire mps_chain_t padLevels,
    // Core command decode from the memory side
    input wire logic coreCmdValid,
    // Serial test output on write strobe lane 0 pad
    output logic writeStrobeLane0Out,
    output logic writeStrobeLane0Oe,
    // Normal-mode write strobe drive request from core
    input wire logic coreStrobeOut,
    input wire logic coreStrobeOe,
    // Mode status to the core
    output logic scanActive,
    output logic cmdExecEnable,
    output logic pinSwapActive,
    output logic caTermNominal,
    output logic dataTermOff,
    // Normal-function shared pins passed to the core
    output mps_shared_pins_s coreSharedPins
);

    // Synchroniser stages for the scan entry pin and the chip select, init clear and pin swap balls
    logic [SYNC_STAGES-1:0] entrySync_r; // Scan entry sync
    logic [SYNC_STAGES-1:0] strobeSync_r; // Scan strobe sync
    logic [SYNC_STAGES-1:0] shiftSync_r; // Shift/capture sync
    logic [SYNC_STAGES-1:0] gateSync_r; // Output gate sync
    logic [SYNC_STAGES-1:0] swapSync_r; // Pin swap sync
    logic strobeLast_r; // Previous synced strobe
    logic entryNow; // Synced entry level
    logic strobeNow; // Synced strobe level
    logic shiftNow; // Synced shift select
    logic gateNow; // Synced gate level
    logic strobeRise; // Rising strobe edge

    // Sequencer
    mps_state_e state_r; // Mode state
    mps_state_e state_nxt; // Next mode state
    logic [7:0] leadCnt_r; // Entry lead counter
    logic scanLatched_r; // Scan entered since power-up

    // Chain and output
    mps_chain_t chain_r; // Chain flops
    mps_chain_t captureVal; // Masked capture value
    logic gate_r; // Registered output gate
    logic fifoInReady; // FIFO accepts a bit
    logic fifoOutValid; // FIFO has a bit
    logic [FIFO_WIDTH-1:0] fifoOutData; // Head bit
    logic fifoPush; // Load head bit
    logic serialBit_r; // Output data flop

    // Two-flop synchronisers; first stage read only by the second
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            entrySync_r <= '0;
            strobeSync_r <= '0;
            shiftSync_r <= '0;
            gateSync_r <= '0;
            swapSync_r <= '0;
        end else begin
            entrySync_r <= {entrySync_r[0], scanEntrySelect};
            strobeSync_r <= {strobeSync_r[0], sharedPins.chipSelectN};
            shiftSync_r <= {shiftSync_r[0], sharedPins.initClearPin};
            gateSync_r <= {gateSync_r[0], sharedPins.pinSwapSelect};
            swapSync_r <= {swapSync_r[0], sharedPins.pinSwapSelect};
        end
    end

    assign entryNow = entrySync_r[SYNC_STAGES-1];
    assign strobeNow = strobeSync_r[SYNC_STAGES-1];
    assign shiftNow = shiftSync_r[SYNC_STAGES-1];
    assign gateNow = gateSync_r[SYNC_STAGES-1];

    // Strobe edge finder
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strobeLast_r <= 1'b0;
        end else begin
            strobeLast_r <= strobeNow;
        end
    end

    // Only a low-to-high strobe transition acts; pulses or bursts alike
    assign strobeRise = strobeNow && !strobeLast_r;

    // Mode sequencer next state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            MPS_IDLE: begin
                if (entryNow) begin
                    state_nxt = MPS_ARMED;
                end
            end
            MPS_ARMED: begin
                if (!entryNow) begin
                    state_nxt = MPS_IDLE;
                end else if (leadCnt_r >= 8'(SCAN_ENTRY_LEAD_CYC)) begin
                    state_nxt = MPS_SCAN;
                end
            end
            MPS_SCAN: begin
                if (!entryNow) begin
                    state_nxt = MPS_IDLE;
                end
            end
            default: state_nxt = MPS_IDLE;
        endcase
    end

    // Mode state register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= MPS_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Entry lead counter, counts while armed
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            leadCnt_r <= '0;
        end else if (state_r == MPS_ARMED) begin
            if (leadCnt_r != 8'hff) begin
                leadCnt_r <= leadCnt_r + 8'h01;
            end
        end else begin
            leadCnt_r <= '0;
        end
    end

    // Once scan entry is seen, normal commands stay off until a power cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scanLatched_r <= 1'b0;
        end else if (entryNow) begin
            scanLatched_r <= 1'b1;
        end
    end

    assign scanActive = (state_r == MPS_SCAN);

    // Capture value with the dead positions forced low
    always_comb begin
        captureVal = padLevels;
        captureVal[POS_UNASSIGNED_A-1] = 1'b0;
        captureVal[POS_UNASSIGNED_B-1] = 1'b0;
        captureVal[POS_SPARE_MARKER-1] = 1'b0;
    end

    // Chain flops: capture or shift toward position 1, tail from ground
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            chain_r <= '0;
        end else if (scanActive && strobeRise) begin
            if (!shiftNow) begin
                chain_r <= captureVal;
            end else if (fifoInReady) begin
                chain_r <= {1'b0, chain_r[CHAIN_LEN-1:1]};
            end
        end
    end

    // Registered output gate, taken on each rising strobe
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            gate_r <= 1'b0;
        end else if (!scanActive) begin
            gate_r <= 1'b0;
        end else if (strobeRise) begin
            gate_r <= gateNow;
        end
    end

    // New head bit enters the FIFO on the same edge as each chain update
    assign fifoPush = scanActive && strobeRise;

    mps_fifo #(
        .WIDTH(FIFO_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) uOutFifo (
        .clk(clk),
        .rst_b(rst_b),
        .flush(!scanActive),
        .inValid(fifoPush),
        .inData(shiftNow ? chain_r[1] : captureVal[0]),
        .inReady(fifoInReady),
        .outValid(fifoOutValid),
        .outData(fifoOutData),
        .outReady(1'b1)
    );

    // Serial data flop follows the stream head
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            serialBit_r <= 1'b0;
        end else if (!scanActive) begin
            serialBit_r <= 1'b0;
        end else if (fifoOutValid) begin
            serialBit_r <= fifoOutData[0];
        end
    end

    // Lane 0 pad: scan data when gated, core strobe in normal mode
    always_comb begin
        if (scanActive) begin
            writeStrobeLane0Out = serialBit_r;
            writeStrobeLane0Oe = gate_r;
        end else if (entryNow || state_r == MPS_ARMED) begin
            writeStrobeLane0Out = 1'b0;
            writeStrobeLane0Oe = 1'b0;
        end else begin
            writeStrobeLane0Out = coreStrobeOut;
            writeStrobeLane0Oe = coreStrobeOe;
        end
    end

    // Command gate and mode-dependent pad settings
    assign cmdExecEnable = coreCmdValid && !entryNow && !scanLatched_r;
    // Swap stays off for the last scan cycle after entry drops, until the sequencer is idle
    assign pinSwapActive = swapSync_r[SYNC_STAGES-1] && !entryNow && !scanActive;
    assign caTermNominal = scanActive;
    assign dataTermOff = scanActive;

    // Shared pins reach the core only outside scan entry
    always_comb begin
        if (entryNow) begin
            coreSharedPins = '0;
        end else begin
            coreSharedPins = sharedPins;
        end
    end

endmodule : mps_scan_chain

// ### bench/mps_scan_chain_sva.sv
// Checker for the ports of the memory pin scan chain
`timescale 1ns/1ps
module mps_scan_chain_chk
    import mps_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Pins seen by the chain
    input wire logic scanEntrySelect,
    input wire mps_shared_pins_s sharedPins,
    input wire logic coreStrobeOut,
    input wire logic coreStrobeOe,
    // Outputs under watch
    input wire logic writeStrobeLane0Out,
    input wire logic writeStrobeLane0Oe,
    input wire logic scanActive,
    input wire logic cmdExecEnable,
    input wire logic pinSwapActive,
    input wire logic caTermNominal,
    input wire logic dataTermOff,
    input wire mps_shared_pins_s coreSharedPins
);
    // One domain, so one clock and one disable for all
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Entry held high reaches scan mode within five cycles
    scan_enter_a: assert property ($rose(scanEntrySelect) ##1 scanEntrySelect [*4] |=> scanActive)
        else $error("scan mode not entered");
    // Entry held low means no scan mode
    scan_exit_a: assert property (!scanEntrySelect [*5] |-> !scanActive)
        else $error("scan mode still active");
    // No command runs in scan mode
    cmd_block_a: assert property (scanActive |-> !cmdExecEnable)
        else $error("command enabled in scan mode");
    // Commands stay blocked after leaving scan
    exit_blocked_a: assert property ($fell(scanActive) |-> !cmdExecEnable [*8])
        else $error("command enabled after scan");
    // Pin swap is off in scan mode
    swap_off_a: assert property (scanActive |-> !pinSwapActive)
        else $error("pin swap active in scan mode");
    // Termination outputs track scan mode
    term_track_a: assert property (caTermNominal == scanActive && dataTermOff == scanActive)
        else $error("termination does not follow scan mode");
    // Shared balls keep their normal role while entry is low
    normal_pins_a: assert property (!scanEntrySelect [*5] |-> coreSharedPins == sharedPins
        && writeStrobeLane0Oe == coreStrobeOe && writeStrobeLane0Out == coreStrobeOut)
        else $error("shared pins not in normal role");
    // Output enable rises only on a strobe with the gate high
    gate_rise_a: assert property (scanActive && $rose(writeStrobeLane0Oe)
        |-> sharedPins.pinSwapSelect && sharedPins.chipSelectN)
        else $error("output enabled without gated strobe");
    // Without a strobe the serial output and its enable stand still
    serial_hold_a: assert property ((scanActive && !sharedPins.chipSelectN) [*5]
        |-> $stable(writeStrobeLane0Out) && $stable(writeStrobeLane0Oe))
        else $error("serial output moved without strobe");
endmodule : mps_scan_chain_chk

bind mps_scan_chain mps_scan_chain_chk chk (.clk(clk), .rst_b(rst_b), .scanEntrySelect(scanEntrySelect),
    .sharedPins(sharedPins), .coreStrobeOut(coreStrobeOut), .coreStrobeOe(coreStrobeOe),
    .writeStrobeLane0Out(writeStrobeLane0Out), .writeStrobeLane0Oe(writeStrobeLane0Oe),
    .scanActive(scanActive), .cmdExecEnable(cmdExecEnable), .pinSwapActive(pinSwapActive),
    .caTermNominal(caTermNominal), .dataTermOff(dataTermOff), .coreSharedPins(coreSharedPins));

// ### bench/mps_tester.sv
// Model of the external tester that drives the scan pins
`timescale 1ns/1ps
module mps_tester
    import mps_pkg::*;
(
    // Clock that paces the pins
    input wire logic clk,
    // Scan pins toward the device
    output mps_scan_pins_s pins
);
    // Entry held low until used; strobe rests low between pulses
    initial pins = '0;
    // Set entry only after reset, then wait out the lead time
    task automatic enter(input logic on);
        @(posedge clk);
        #1 pins.scanEntrySelect = on;
        repeat (6) @(posedge clk);
    endtask : enter
    // One strobe period of 125 ns: 13 cycles low with setup, 12 high
    task automatic pulse(input logic sh, input logic gt);
        @(posedge clk);
        #1 pins.shiftCaptureSelect = sh;
        pins.testOutGate = gt;
        repeat (12) @(posedge clk);
        #1 pins.scanStrobe = 1'b1;
        repeat (12) @(posedge clk);
        #1 pins.scanStrobe = 1'b0;
    endtask : pulse
endmodule : mps_tester

// ### bench/memory_pin_scan_chain_bench.sv
// Self-checking bench for the memory pin scan chain
`timescale 1ns/1ps
module memory_pin_scan_chain_bench;
    import mps_pkg::*;
    // Clock, reset and core side stimulus
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic coreCmdValid = 1'b1;
    logic coreStrobeOut = 1'b1;
    logic coreStrobeOe = 1'b1;
    logic laneIn = 1'b0;
    mps_chain_t padLevels = '0;
    // Tester pins and device outputs
    mps_scan_pins_s tp;
    mps_shared_pins_s sharedPins;
    mps_shared_pins_s coreSharedPins;
    logic laneOut, laneOe, scanActive, cmdExecEnable, pinSwapActive, caTermNominal, dataTermOff;
    // Pad pattern, expected chain and counters
    mps_chain_t pat = 67'h7_fbdc_ba98_ffff_7654;
    mps_chain_t exp;
    int bad_count = 0;
    int check_count = 0;
    // Clock of 5 ns period
    always #2.5 clk = ~clk;
    // Tester pins land on the shared balls
    assign sharedPins = {tp.shiftCaptureSelect, tp.testOutGate, tp.scanStrobe, laneIn};
    mps_tester t (.clk(clk), .pins(tp));
    mps_scan_chain dut (.clk(clk), .rst_b(rst_b), .scanEntrySelect(tp.scanEntrySelect), .sharedPins(sharedPins),
        .padLevels(padLevels), .coreCmdValid(coreCmdValid), .writeStrobeLane0Out(laneOut),
        .writeStrobeLane0Oe(laneOe), .coreStrobeOut(coreStrobeOut), .coreStrobeOe(coreStrobeOe),
        .scanActive(scanActive), .cmdExecEnable(cmdExecEnable), .pinSwapActive(pinSwapActive),
        .caTermNominal(caTermNominal), .dataTermOff(dataTermOff), .coreSharedPins(coreSharedPins));
    // Compare and count
    task automatic check(input string name, input logic [66:0] seen, input logic [66:0] want);
        check_count++;
        if (seen !== want) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", name, want, seen);
        end
    endtask : check
    // Print counts and verdict, then stop
    task automatic finish_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    // Shared balls act normally while entry is low
    task automatic t_normal();
        t.pins.shiftCaptureSelect = 1'b1;
        t.pins.testOutGate = 1'b1;
        laneIn = 1'b1;
        coreStrobeOut = 1'b0;
        repeat (4) @(posedge clk);
        #1 check("scanActive", scanActive, 1'b0);
        check("cmdExec", cmdExecEnable, 1'b1);
        check("corePins", coreSharedPins, sharedPins);
        check("swap", pinSwapActive, 1'b1);
        check("laneOe", laneOe, coreStrobeOe);
        check("laneOut", laneOut, 1'b0);
        // A dropped core command must not be enabled
        coreCmdValid = 1'b0;
        @(posedge clk);
        #1 check("cmdGate", cmdExecEnable, 1'b0);
        coreCmdValid = 1'b1;
    endtask : t_normal
    // Entering scan mode switches the mode outputs
    task automatic t_enter();
        t.enter(1'b1);
        #1 check("scanActive", scanActive, 1'b1);
        check("caTerm", caTermNominal, 1'b1);
        check("dataTerm", dataTermOff, 1'b1);
        check("cmdExec", cmdExecEnable, 1'b0);
        check("swap", pinSwapActive, 1'b0);
        check("laneOe", laneOe, 1'b0);
    endtask : t_enter
    // Capture, then shift the whole chain and past its tail
    task automatic t_chain();
        exp = pat;
        exp[POS_SPARE_MARKER - 1] = 1'b0;
        exp[POS_UNASSIGNED_A - 1] = 1'b0;
        exp[POS_UNASSIGNED_B - 1] = 1'b0;
        padLevels = pat;
        t.pulse(1'b0, 1'b1);
        padLevels = ~pat;
        check("first", laneOut, exp[0]);
        check("gateOn", laneOe, 1'b1);
        for (int i = 1; i < CHAIN_LEN + 3; i++) begin
            t.pulse(1'b1, 1'b1);
            check("shift", laneOut, (i < CHAIN_LEN) ? exp[i] : 1'b0);
        end
    endtask : t_chain
    // Gate low hides the output while the chain still captures
    task automatic t_gate();
        padLevels = pat;
        t.pulse(1'b0, 1'b0);
        check("gateOff", laneOe, 1'b0);
        t.pulse(1'b1, 1'b1);
        check("advance", laneOut, exp[1]);
        check("gateOn", laneOe, 1'b1);
    endtask : t_gate
    // Leaving scan keeps commands blocked until a power cycle
    task automatic t_exit();
        t.enter(1'b0);
        #1 check("scanActive", scanActive, 1'b0);
        check("laneOe", laneOe, coreStrobeOe);
        check("corePins", coreSharedPins, sharedPins);
        check("cmdExec", cmdExecEnable, 1'b0);
        check("laneOut", laneOut, coreStrobeOut);
        check("caTerm", caTermNominal, 1'b0);
        check("dataTerm", dataTermOff, 1'b0);
        rst_b = 1'b0;
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        t.pulse(1'b0, 1'b1);
        check("cmdExec", cmdExecEnable, 1'b1);
        check("scanActive", scanActive, 1'b0);
        check("swap", pinSwapActive, 1'b1);
    endtask : t_exit
    // Cut a hang short
    initial begin
        #100000;
        bad_count++;
        finish_test();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk);
        #1 rst_b = 1'b1;
        t_normal();
        t_enter();
        t_chain();
        t_gate();
        t_exit();
        finish_test();
    end
endmodule : memory_pin_scan_chain_bench
